// file: rtl/cmpl_pkg.sv
// constants for the comparator gate and set-reset latch block
`default_nettype none

package cmpl_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] CMP2_CTRL_OFS  = 4'h0;
  localparam logic [3:0] AUX_CTRL_OFS   = 4'h4;
  localparam logic [3:0] LATCH_CTRL_OFS = 4'h8;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CMP2_ON_BIT        = 7;
  localparam int CMP2_RESULT_BIT    = 6;
  localparam int CMP2_PIN_DRIVE_BIT = 5;
  localparam int CMP2_INVERT_BIT    = 4;
  localparam int CMP2_REF_SEL_BIT   = 2;
  localparam int CMP2_INPUT_SEL_LSB = 0;
  localparam int MIRROR_CMP1_BIT    = 7;
  localparam int MIRROR_CMP2_BIT    = 6;
  localparam int GATE_SRC_SEL_BIT   = 1;
  localparam int CMP2_SYNC_EN_BIT   = 0;
  localparam int LATCH_CFG_LSB      = 6;
  localparam int LATCH_SET_BIT      = 3;
  localparam int LATCH_RESET_BIT    = 2;

  // ------------------------------------------------------------------
  // reset values and write masks
  // ------------------------------------------------------------------
  localparam logic [7:0] CMP2_CTRL_RST  = 8'h00;
  localparam logic [7:0] AUX_CTRL_RST   = 8'h02;
  localparam logic [1:0] LATCH_CFG_RST  = 2'h0;
  localparam logic [7:0] CMP2_CTRL_WMSK = 8'hb7;
  localparam logic [7:0] AUX_CTRL_WMSK  = 8'h03;

  // ------------------------------------------------------------------
  // bus responses and register selectors
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_NONE  = 4'h1,
    REG_CMP2  = 4'h2,
    REG_AUX   = 4'h4,
    REG_LATCH = 4'h8
  } cmpl_reg_type;

endpackage

`default_nettype wire

// file: rtl/cmpl_sync3.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none

module cmpl_sync3
  import cmpl_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // asynchronous inputs and filtered levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] level_out
);

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] agree;

  // ------------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------------
  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
    end else begin
      ff1_r <= async_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // a change counts once stage two and three agree
  assign agree = ~(ff2_r ^ ff3_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= '0;
    end else begin
      level_out <= (agree & ff2_r) | (~agree & level_out);
    end
  end

endmodule

`default_nettype wire

// file: rtl/cmpl_sr_latch.sv
// reset-dominant set-reset latch with combinational outputs
`default_nettype none

module cmpl_sr_latch
  import cmpl_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // latch inputs, active high
  input  wire logic set_in,
  input  wire logic reset_in,
  // latch outputs
  output logic      q,
  output logic      q_n
);

  logic q_r;

  // outputs follow set and reset at once, no clock edge needed
  always_comb begin
    if (reset_in) begin
      q = 1'b0;
    end else if (set_in) begin
      q = 1'b1;
    end else begin
      q = q_r;
    end
  end

  assign q_n = ~q;

  // holds the state once both inputs fall low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q;
    end
  end

endmodule

`default_nettype wire

// file: rtl/cmpl_top.sv
// comparator 2 control, timer gating and set-reset latch routing
`default_nettype none

module cmpl_top
  import cmpl_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int LVL_W  = 8,
  parameter int PORT_W = 8
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,

  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,

  // sampled analog levels, aclk domain
  input  wire logic [LVL_W-1:0]     noninv_ref_lvl,
  input  wire logic [LVL_W-1:0]     noninv_pin_lvl,
  input  wire logic [4*LVL_W-1:0]   shared_analog_pin_lvl,

  // comparator 1 side, aclk domain
  input  wire logic                 cmp1_result,
  input  wire logic                 cmp1_pin_drive_ok,

  // comparator pin logic
  input  wire logic                 pin_direction_c1,
  input  wire logic                 pin_direction_c2,
  output var  logic                 pin1_out,
  output var  logic                 pin1_oe,
  output var  logic                 pin2_out,
  output var  logic                 pin2_oe,

  // digital port read path
  input  wire logic [PORT_W-1:0]    port_pin_in,
  input  wire logic [PORT_W-1:0]    port_analog_sel,
  output var  logic [PORT_W-1:0]    port_read_data,

  // general-purpose timer side
  input  wire logic                 tmr_clk_pin,
  input  wire logic                 timer_gate_pin,
  input  wire logic                 timer_on,
  input  wire logic                 timer_gate_en,
  output var  logic                 cmp2_synced_out,
  output var  logic                 timer_gate,
  output var  logic                 timer_count_en
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  localparam int SYNC_W = PORT_W + 2;

  // register state
  logic [7:0]        cmp2_ctrl_r;
  logic [7:0]        aux_ctrl_r;
  logic [1:0]        latch_out_cfg_r;
  logic              latch_set_pulse_r;
  logic              latch_reset_pulse_r;

  // decoded control fields
  logic              cmp2_on;
  logic              cmp2_pin_drive;
  logic              cmp2_invert;
  logic              cmp2_ref_sel;
  logic [1:0]        cmp2_input_sel;
  logic              gate_source_sel;
  logic              cmp2_sync_en;

  // comparator datapath
  logic [LVL_W-1:0]  cmp2_noninv_in;
  logic [LVL_W-1:0]  cmp2_inv_in;
  logic              cmp2_result_r;
  logic              cmp2_capture_r;

  // synchronised pins
  logic [SYNC_W-1:0] sync_level;
  logic [PORT_W-1:0] port_level;
  logic              tmr_clk_level;
  logic              gate_pin_level;
  logic              tmr_clk_prev_r;
  logic              tmr_clk_fall;
  logic              gate_sel;

  // latch
  logic              latch_set;
  logic              latch_reset;
  logic              latch_q;
  logic              latch_q_n;

  // write and read channels
  logic              aw_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_hold_r;
  logic [7:0]        w_data_r;
  logic              w_lane0_r;
  logic              do_write;
  cmpl_reg_type      wr_sel;
  cmpl_reg_type      rd_sel;
  logic [7:0]        rd_byte;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // maps a byte address to a register selector
  function automatic cmpl_reg_type reg_decode(
    input logic [ADDR_W-1:0] addr
  );
    cmpl_reg_type sel;
    sel = REG_NONE;
    if (addr == ADDR_W'(CMP2_CTRL_OFS)) begin
      sel = REG_CMP2;
    end else if (addr == ADDR_W'(AUX_CTRL_OFS)) begin
      sel = REG_AUX;
    end else if (addr == ADDR_W'(LATCH_CTRL_OFS)) begin
      sel = REG_LATCH;
    end
    return sel;
  endfunction

  // ------------------------------------------------------------------
  // control field aliases
  // ------------------------------------------------------------------
  assign cmp2_on         = cmp2_ctrl_r[CMP2_ON_BIT];
  assign cmp2_pin_drive  = cmp2_ctrl_r[CMP2_PIN_DRIVE_BIT];
  assign cmp2_invert     = cmp2_ctrl_r[CMP2_INVERT_BIT];
  assign cmp2_ref_sel    = cmp2_ctrl_r[CMP2_REF_SEL_BIT];
  assign cmp2_input_sel  = cmp2_ctrl_r[CMP2_INPUT_SEL_LSB +: 2];
  assign gate_source_sel = aux_ctrl_r[GATE_SRC_SEL_BIT];
  assign cmp2_sync_en    = aux_ctrl_r[CMP2_SYNC_EN_BIT];

  // ------------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------------
  // address and data are taken in either order
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign do_write      = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wr_sel        = reg_decode(aw_addr_r);

  // holds the write address until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  // holds the low data byte and its strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r  <= 1'b1;
      w_data_r  <= s_axi_wdata[7:0];
      w_lane0_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  // write response, slave error for unmapped addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // comparator 2 control, result bit is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp2_ctrl_r <= CMP2_CTRL_RST;
    end else if (do_write && w_lane0_r && wr_sel == REG_CMP2) begin
      cmp2_ctrl_r <= w_data_r & CMP2_CTRL_WMSK;
    end
  end

  // gate source and sync enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_ctrl_r <= AUX_CTRL_RST;
    end else if (do_write && w_lane0_r && wr_sel == REG_AUX) begin
      aux_ctrl_r <= w_data_r & AUX_CTRL_WMSK;
    end
  end

  // routing field, unlatched mode after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_out_cfg_r <= LATCH_CFG_RST;
    end else if (do_write && w_lane0_r && wr_sel == REG_LATCH) begin
      latch_out_cfg_r <= w_data_r[LATCH_CFG_LSB +: 2];
    end
  end

  // pulse bits last one cycle after the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_set_pulse_r   <= 1'b0;
      latch_reset_pulse_r <= 1'b0;
    end else if (do_write && w_lane0_r && wr_sel == REG_LATCH) begin
      latch_set_pulse_r   <= w_data_r[LATCH_SET_BIT];
      latch_reset_pulse_r <= w_data_r[LATCH_RESET_BIT];
    end else begin
      latch_set_pulse_r   <= 1'b0;
      latch_reset_pulse_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_sel        = reg_decode(s_axi_araddr);

  // read mux; reads have no side effects on any state
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_sel)
      REG_CMP2: begin
        rd_byte = cmp2_ctrl_r;
        rd_byte[CMP2_RESULT_BIT] = cmp2_result_r;
      end
      REG_AUX: begin
        rd_byte = aux_ctrl_r;
        rd_byte[MIRROR_CMP1_BIT] = cmp1_result;
        rd_byte[MIRROR_CMP2_BIT] = cmp2_result_r;
      end
      REG_LATCH: begin
        rd_byte[LATCH_CFG_LSB +: 2] = latch_out_cfg_r;
        rd_byte[LATCH_SET_BIT]      = latch_set_pulse_r;
        rd_byte[LATCH_RESET_BIT]    = latch_reset_pulse_r;
      end
      REG_NONE: begin
        rd_byte = 8'h00;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // read data and response, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // comparator 2 evaluation
  // ------------------------------------------------------------------
  // source selection for both comparator inputs
  assign cmp2_noninv_in = cmp2_ref_sel ? noninv_ref_lvl
                                       : noninv_pin_lvl;
  assign cmp2_inv_in    =
    shared_analog_pin_lvl[cmp2_input_sel * LVL_W +: LVL_W];

  // result reads 0 while the comparator is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp2_result_r <= 1'b0;
    end else begin
      cmp2_result_r <= cmp2_on &
        ((cmp2_noninv_in > cmp2_inv_in) ^ cmp2_invert);
    end
  end

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  cmpl_sync3 #(
    .W (SYNC_W)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .async_in  ({timer_gate_pin, tmr_clk_pin, port_pin_in}),
    .level_out (sync_level)
  );

  assign port_level     = sync_level[PORT_W-1:0];
  assign tmr_clk_level  = sync_level[PORT_W];
  assign gate_pin_level = sync_level[PORT_W+1];

  // analog pins read back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_read_data <= '0;
    end else begin
      port_read_data <= port_level & ~port_analog_sel;
    end
  end

  // ------------------------------------------------------------------
  // timer clock capture
  // ------------------------------------------------------------------
  // the timer clock seen here is already prescaled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_clk_prev_r <= 1'b0;
    end else begin
      tmr_clk_prev_r <= tmr_clk_level;
    end
  end

  // timer counts on rise, so capture on fall
  assign tmr_clk_fall = tmr_clk_prev_r & ~tmr_clk_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp2_capture_r <= 1'b0;
    end else if (tmr_clk_fall) begin
      cmp2_capture_r <= cmp2_result_r;
    end
  end

  // captured or pass-through result
  assign cmp2_synced_out = cmp2_sync_en ? cmp2_capture_r
                                        : cmp2_result_r;

  // ------------------------------------------------------------------
  // timer gate
  // ------------------------------------------------------------------
  // 1 selects the gate pin, 0 the synced comparator result
  assign gate_sel = gate_source_sel ? gate_pin_level
                                    : cmp2_synced_out;

  // gating only matters while the timer runs with gate enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_gate     <= 1'b0;
      timer_count_en <= 1'b0;
    end else begin
      timer_gate     <= gate_sel;
      timer_count_en <= timer_on & (~timer_gate_en | gate_sel);
    end
  end

  // ------------------------------------------------------------------
  // set-reset latch
  // ------------------------------------------------------------------
  assign latch_set   = cmp1_result | latch_set_pulse_r;
  assign latch_reset = cmp2_result_r | latch_reset_pulse_r;

  cmpl_sr_latch u_latch (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .set_in   (latch_set),
    .reset_in (latch_reset),
    .q        (latch_q),
    .q_n      (latch_q_n)
  );

  // ------------------------------------------------------------------
  // pin output muxes
  // ------------------------------------------------------------------
  // routing bit 0 puts q on pin 1, bit 1 puts q_n on pin 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_out <= 1'b0;
      pin2_out <= 1'b0;
    end else begin
      pin1_out <= latch_out_cfg_r[0] ? latch_q : cmp1_result;
      pin2_out <= latch_out_cfg_r[1] ? latch_q_n : cmp2_result_r;
    end
  end

  // pin 2 drive needs drive bit, on bit and output direction; pin 1 needs cmp1_pin_drive_ok and output direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_oe <= 1'b0;
      pin2_oe <= 1'b0;
    end else begin
      pin1_oe <= cmp1_pin_drive_ok & ~pin_direction_c1;
      pin2_oe <= cmp2_pin_drive & cmp2_on & ~pin_direction_c2;
    end
  end

endmodule

`default_nettype wire

// file: dv/cmpl_props.sv
// checker watching the bus and pin outputs of the comparator block
`default_nettype none
module cmpl_props
  import cmpl_pkg::*;
#(parameter int ADDR_W = 4, parameter int PORT_W = 8) (
  // bus, pin and timer ports
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cmp1_result, cmp1_pin_drive_ok, pin_direction_c1,
  input wire logic pin_direction_c2, pin1_oe, pin2_oe, timer_on,
  input wire logic [PORT_W-1:0] port_analog_sel, port_read_data,
  input wire logic timer_gate_en, timer_gate, timer_count_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic aux_r;
  // remembers whether the read in flight targets the aux register
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready)
      aux_r <= (s_axi_araddr == AUX_CTRL_OFS);
  end
  property p_pin2_oe; pin2_oe |-> !$past(pin_direction_c2); endproperty
  a_pin2_oe: assert property (p_pin2_oe) else $error("pin2 driven");
  property p_pin1_oe; $past(aresetn) |->
    pin1_oe == $past(cmp1_pin_drive_ok && !pin_direction_c1); endproperty
  a_pin1_oe: assert property (p_pin1_oe) else $error("pin1 oe");
  property p_ana; $past(aresetn) |->
    (port_read_data & $past(port_analog_sel)) == '0; endproperty
  a_ana: assert property (p_ana) else $error("analog pin read 1");
  property p_cnt; $past(aresetn) |-> timer_count_en ==
    ($past(timer_on) && (!$past(timer_gate_en) || timer_gate)); endproperty
  a_cnt: assert property (p_cnt) else $error("count enable");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_b_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_b_resp: assert property (p_b_resp) else $error("no write response");
  property p_aux; $rose(s_axi_rvalid) && aux_r |-> s_axi_rdata[5:2] == 4'h0
    && s_axi_rdata[7] == $past(cmp1_result); endproperty
  a_aux: assert property (p_aux) else $error("aux read");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read overlap");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_aux: cover property ($rose(s_axi_rvalid) && aux_r);
  c_gate: cover property (timer_count_en && timer_gate_en);
endmodule
bind cmpl_top cmpl_props #(.ADDR_W(ADDR_W), .PORT_W(PORT_W))
  cmpl_props_inst (.*);
`default_nettype wire

// file: dv/cmpl_timer_model.sv
// prescaled timer clock source and gated counter on the far side
`default_nettype none
module cmpl_timer_model (
  input wire logic aclk, run, count_en,
  output var logic tclk,
  output var logic [15:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div = '0;
  initial tclk = 1'b0;
  initial count = '0;
  // prescaled clock, still while the timer is stopped
  always @(posedge aclk) begin
    div <= run ? div + 3'd1 : 3'd0;
    tclk <= run ? tclk ^ (div == 3'd7) : 1'b0;
  end
  // the counter moves on the rising timer clock edge only
  always @(posedge tclk) if (count_en) count <= count + 16'd1;
endmodule
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the comparator gate and latch block
`default_nettype none
module testbench import cmpl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0,
    s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, cmp1_result = 0,
    cmp1_pin_drive_ok = 0, pin_direction_c1 = 0, pin_direction_c2 = 0,
    timer_gate_pin = 0, timer_on = 0, timer_gate_en = 0, run = 0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, shared_analog_pin_lvl = '0, s_axi_rdata;
  logic [7:0] noninv_ref_lvl = '0, noninv_pin_lvl = '0, port_pin_in = '0,
    port_analog_sel = '0, port_read_data;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready,
    s_axi_rvalid, pin1_out, pin1_oe, pin2_out, pin2_oe, tmr_clk_pin,
    cmp2_synced_out, timer_gate, timer_count_en;
  logic [15:0] count;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0, samples_checked = 0;
  cmpl_top cmpl_top_inst (.*);
  cmpl_timer_model cmpl_timer_model_inst (.aclk, .run,
    .count_en(timer_count_en), .tclk(tmr_clk_pin), .count);
  initial forever #2 aclk = ~aclk;
  // ----------------------------------------------------------------
  // compare, bus tasks and closing
  // ----------------------------------------------------------------
  task automatic cmp(logic [33:0] got, logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d, logic [1:0] r = 0);
    bit ad, wd;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) ad = 1;
      if (s_axi_wvalid && s_axi_wready) wd = 1;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk) s_axi_bready <= 1;
    @(posedge aclk) s_axi_bready <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] d, logic [1:0] r = 0);
    rq.push_back({r, 24'h00_0000, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk) s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk) s_axi_rready <= 1;
    @(posedge aclk) s_axi_rready <= 0;
  endtask
  task automatic pins(logic e1, logic e2);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    cmp(pin1_out, e1);
    cmp(pin2_out, e2);
  endtask
  // answers are compared against the oldest note as they appear
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata},
      rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp(s_axi_bresp, bq.pop_front());
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] sh;
    logic [7:0] rf, pl;
    logic res, c1;
    void'($urandom(83128));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    cmp1_result <= 1;
    pins(1, 0);
    rd(CMP2_CTRL_OFS, 8'h00);
    rd(AUX_CTRL_OFS, 8'h82);
    rd(4'hc, 8'h00, RESP_SLVERR);
    wr(4'hc, 8'hff, RESP_SLVERR);
    $display("reset and map test done");
    for (int i = 0; i < 16; i++) begin
      sh = $urandom;
      rf = $urandom;
      pl = $urandom;
      c1 = $urandom;
      shared_analog_pin_lvl <= sh;
      noninv_ref_lvl <= rf;
      noninv_pin_lvl <= pl;
      cmp1_result <= c1;
      pin_direction_c2 <= i[0];
      res = ((i[3] ? rf : pl) > sh[8*i[1:0]+:8]) ^ i[2];
      wr(CMP2_CTRL_OFS, {3'b101, i[2], 1'b0, i[3], i[1:0]});
      rd(CMP2_CTRL_OFS, {1'b1,res,1'b1,i[2],1'b0,i[3],i[1:0]});
      rd(AUX_CTRL_OFS, {c1, res, 6'h02});
      pins(c1, res);
      cmp(pin2_oe, !i[0]);
    end
    $display("comparator test done");
    noninv_ref_lvl <= 8'h00;
    shared_analog_pin_lvl <= '0;
    cmp1_result <= 0;
    wr(CMP2_CTRL_OFS, 8'ha4);
    wr(LATCH_CTRL_OFS, 8'hc8);
    pins(1, 0);
    rd(LATCH_CTRL_OFS, 8'hc0);
    wr(LATCH_CTRL_OFS, 8'hc4);
    pins(0, 1);
    wr(LATCH_CTRL_OFS, 8'hc8);
    wr(LATCH_CTRL_OFS, 8'hcc);
    pins(0, 1);
    cmp1_result <= 1;
    pins(1, 0);
    noninv_ref_lvl <= 8'hff;
    pins(0, 1);
    wr(LATCH_CTRL_OFS, 8'h40);
    pins(0, 1);
    wr(LATCH_CTRL_OFS, 8'h80);
    pins(1, 1);
    $display("latch test done");
    wr(AUX_CTRL_OFS, 8'h01);
    timer_on <= 1;
    timer_gate_en <= 1;
    run <= 1;
    repeat (60) @(posedge aclk);
    cmp({timer_gate, timer_count_en}, 2'b11);
    noninv_ref_lvl <= 8'h00;
    repeat (60) @(posedge aclk);
    cmp({timer_gate, timer_count_en}, 2'b00);
    cmp(count != 0, 1);
    timer_gate_pin <= 1;
    wr(AUX_CTRL_OFS, 8'h03);
    repeat (10) @(posedge aclk);
    cmp(timer_gate, 1);
    run <= 0;
    repeat (10) @(posedge aclk);
    noninv_ref_lvl <= 8'hff;
    repeat (4) @(posedge aclk);
    cmp(cmp2_synced_out, 0);
    wr(AUX_CTRL_OFS, 8'h02);
    cmp(cmp2_synced_out, 1);
    $display("timer gate test done");
    port_pin_in <= $urandom;
    port_analog_sel <= $urandom;
    repeat (8) @(posedge aclk);
    cmp(port_read_data, port_pin_in & ~port_analog_sel);
    $display("port read test done");
    end_of_test();
  end
endmodule
`default_nettype wire
